// file: shared/asr_params.svh
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// Result width and saturation codes
`define ASR_RES_BITS      16
`define ASR_FULL_SCALE    16'hFFFF
`define ASR_ZERO_SCALE    16'h0000

// Core clock rate in MHz
`define ASR_CLK_MHZ       50

// Conversion time limits in ns
`define ASR_CONV_MIN_NS   500
`define ASR_CONV_MAX_NS   700

// Least time rounds up, longest time rounds down
`define ASR_CONV_MIN_CYC  ((`ASR_CONV_MIN_NS * `ASR_CLK_MHZ + 999) / 1000)
`define ASR_CONV_MAX_CYC  ((`ASR_CONV_MAX_NS * `ASR_CLK_MHZ) / 1000)

// Serial clock falling edge counter width
`define ASR_EDGE_BITS     6

// Falling edge that ends a frame, without and with start bit
`define ASR_PLAIN_LAST    6'h10
`define ASR_BUSY_LAST     6'h11

`endif

// file: shared/asr_pkg.sv
`include "asr_params.svh"

package asr_pkg;

  // Conversion sequencer states
  typedef enum logic [0:0] {
    CONV_IDLE,
    CONV_RUN
  } asr_conv_e;

  // Output pin states
  typedef enum logic [1:0] {
    OUT_FLOAT,
    OUT_HOLD,
    OUT_DATA
  } asr_out_e;

  // Sampled analog value from the front end
  typedef struct packed {
    logic [`ASR_RES_BITS-1:0] code;
    logic                     over_range;
    logic                     under_range;
  } asr_sample_s;

  // Serial output pin with its enable
  typedef struct packed {
    logic data;
    logic enable;
  } asr_pin_s;

endpackage

// file: hdl/asr_conv.sv
`include "asr_params.svh"

module asr_conv
  import asr_pkg::*;
#(
  parameter int CONV_CYCLES = `ASR_CONV_MAX_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     start,
  input  wire asr_sample_s              sample,
  output logic                          done,
  output logic [`ASR_RES_BITS-1:0]      result
);

  // Run length kept inside the documented window
  localparam int RUN_LEN = (CONV_CYCLES < `ASR_CONV_MIN_CYC) ?
                           `ASR_CONV_MIN_CYC :
                           (CONV_CYCLES > `ASR_CONV_MAX_CYC) ?
                           `ASR_CONV_MAX_CYC : CONV_CYCLES;
  localparam int CW = $clog2(RUN_LEN + 1);

  logic [CW-1:0]   count;   // Cycles left in this conversion
  asr_sample_s     held;    // Sample frozen at conversion start
  logic [`ASR_RES_BITS-1:0] coded;  // Saturated output code

  // Over range wins to full scale, under range to zero
  assign coded = held.over_range  ? `ASR_FULL_SCALE :
                 held.under_range ? `ASR_ZERO_SCALE : held.code;

  // Internal timer, blind to the serial clock
  // Loaded one short, since the done flop adds the last cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      held  <= '0;
    end else if (start && count == '0) begin
      count <= CW'(RUN_LEN - 1);
      held  <= sample;
    end else if (count != '0) begin
      count <= count - CW'(1);
    end
  end

  // Done pulse and result on the last timer cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done   <= 1'b0;
      result <= '0;
    end else begin
      done <= (count == CW'(1));
      if (count == CW'(1)) begin
        result <= coded;
      end
    end
  end

endmodule // asr_conv

// file: hdl/asr_readout.sv
// How it works
// - Data input at start edge picks mode
// - Tied inputs resolve to chain mode
// - Optional start bit serves as busy flag
// - Select mode busy if either input low
// - Chain mode busy if clock high
// - Start edge with input high floats output
// - Conversion ignores later start pin changes
// - After conversion return to acquisition, power down
// - Select falling drives MSB, clock falls shift
// - Each bit valid across both clock edges
// - Float after sixteenth fall or deselect
// - Busy variant floats until conversion ends
// - Busy drives output low at completion in select mode, high in chain mode
// - Busy variant floats after seventeenth fall
// - Both inputs low drive output low when not converting or reading out
// - Four wire data input low drives MSB
// - Straight binary result, saturating at ends
`include "asr_params.svh"

module asr_readout
  import asr_pkg::*;
#(
  parameter int CONV_CYCLES = `ASR_CONV_MAX_CYC,
  parameter int EDGE_BITS   = `ASR_EDGE_BITS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sck,
  input  wire logic        convert_start,
  input  wire logic        serial_data_in,
  input  wire asr_sample_s analog_sample,
  output logic             serial_data_out,
  output logic             serial_data_out_en,
  output logic             power_down,
  output logic             converting
);

  localparam int RB = `ASR_RES_BITS;

  // Gray to binary, for the crossed edge count
  function automatic logic [EDGE_BITS-1:0] gray_to_bin(
    input logic [EDGE_BITS-1:0] g
  );
    logic [EDGE_BITS-1:0] b;
    b = '0;
    b[EDGE_BITS-1] = g[EDGE_BITS-1];
    for (int i = EDGE_BITS - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Bit on the wire for a given edge index
  function automatic logic pick_bit(
    input logic [RB-1:0]        word,
    input logic [EDGE_BITS-1:0] idx,
    input logic                 lead,
    input logic                 start_val
  );
    logic [EDGE_BITS-1:0] pos;
    pos = idx - EDGE_BITS'(lead);
    if (lead && idx == '0) begin
      return start_val;
    end
    return word[4'hF - pos[3:0]];
  endfunction

  // ---------------- Serial clock domain ----------------
  logic [EDGE_BITS-1:0] edge_bin;   // Falling edges seen, binary
  logic [EDGE_BITS-1:0] edge_gray;  // Same count, gray, crosses out

  // Free running count of falling edges; idle clock is harmless
  always_ff @(negedge sck or negedge reset_n) begin
    if (!reset_n) begin
      edge_bin  <= '0;
      edge_gray <= '0;
    end else begin
      edge_bin  <= edge_bin + EDGE_BITS'(1);
      edge_gray <= (edge_bin + EDGE_BITS'(1)) ^
                   ((edge_bin + EDGE_BITS'(1)) >> 1);
    end
  end

  // ---------------- Core clock domain ----------------
  logic [1:0] rst_pipe;            // Reset release synchroniser
  logic       rst_n;               // Released reset for the core

  // Reset asserts at once, releases after two edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  logic cnv_meta, cnv_s, cnv_q;    // Start pin sync and delay
  logic sdi_meta, sdi_s, sdi_q;    // Data input sync and delay
  logic sck_meta, sck_s;           // Clock level, read as data
  logic [EDGE_BITS-1:0] gray_meta; // First stage of count crossing
  logic [EDGE_BITS-1:0] gray_s;    // Second stage of count crossing

  // Pins pass two flops before any logic reads them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnv_meta  <= 1'b0;
      cnv_s     <= 1'b0;
      sdi_meta  <= 1'b0;
      sdi_s     <= 1'b0;
      sck_meta  <= 1'b0;
      sck_s     <= 1'b0;
      gray_meta <= '0;
      gray_s    <= '0;
    end else begin
      cnv_meta  <= convert_start;
      cnv_s     <= cnv_meta;
      sdi_meta  <= serial_data_in;
      sdi_s     <= sdi_meta;
      sck_meta  <= sck;
      sck_s     <= sck_meta;
      gray_meta <= edge_gray;
      gray_s    <= gray_meta;
    end
  end

  // One cycle old copies for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnv_q <= 1'b0;
      sdi_q <= 1'b0;
    end else begin
      cnv_q <= cnv_s;
      sdi_q <= sdi_s;
    end
  end

  // Decoded pin events
  wire                 cnv_rise  = cnv_s & ~cnv_q;
  wire                 selected  = ~(cnv_s & sdi_s);
  wire                 both_low  = ~cnv_s & ~sdi_s;
  wire [EDGE_BITS-1:0] edge_cnt  = gray_to_bin(gray_s);

  asr_conv_e conv_state;           // Conversion sequencer
  asr_conv_e next_conv_state;
  logic      conv_done;            // Pulse from the timer
  logic [RB-1:0] conv_result;      // Saturated code from the timer

  // Start is taken only while idle; repeats are ignored
  wire start = cnv_rise && conv_state == CONV_IDLE;

  // Sequencer: acquisition until start, run until done
  always_comb begin
    next_conv_state = conv_state;
    case (conv_state)
      CONV_IDLE: begin
        if (start) begin
          next_conv_state = CONV_RUN;
        end
      end
      CONV_RUN: begin
        if (conv_done) begin
          next_conv_state = CONV_IDLE;
        end
      end
      default: begin
        next_conv_state = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_state <= CONV_IDLE;
    end else begin
      conv_state <= next_conv_state;
    end
  end

  // Conversion timer and saturation
  asr_conv #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (start),
    .sample (analog_sample),
    .done   (conv_done),
    .result (conv_result)
  );

  logic select_mode;   // High for select mode, low for chain
  logic chain_busy;    // Clock level caught at start edge

  // Mode caught at start; old data level gives tied pins chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      select_mode <= 1'b1;
      chain_busy  <= 1'b0;
    end else if (start) begin
      select_mode <= sdi_q;
      chain_busy  <= sck_s;
    end
  end

  // Busy choice at completion, per mode
  wire busy_on = select_mode ? (~cnv_s | ~sdi_s)
                             : chain_busy;

  asr_out_e            out_state;  // Output pin state
  asr_out_e            next_out_state;
  logic [RB-1:0]       shreg;      // Result held for readout
  logic [EDGE_BITS-1:0] base;      // Edge count at frame start
  logic [EDGE_BITS-1:0] next_base;
  logic                lead;       // Frame carries a start bit
  logic                next_lead;

  // Falling edges since frame start, and the frame end
  wire [EDGE_BITS-1:0] idx      = edge_cnt - base;
  wire [EDGE_BITS-1:0] last     = lead ? `ASR_BUSY_LAST
                                       : `ASR_PLAIN_LAST;
  wire                 at_end   = idx >= last;
  wire                 deselect = select_mode && !selected;

  // Output state flow; start and completion take priority
  always_comb begin
    next_out_state = out_state;
    next_base      = base;
    next_lead      = lead;
    case (out_state)
      OUT_FLOAT, OUT_HOLD, OUT_DATA: begin
        if (start) begin
          next_out_state = OUT_FLOAT;
        end else if (conv_done) begin
          next_base = edge_cnt;
          next_lead = busy_on;
          if (busy_on || !select_mode) begin
            next_out_state = OUT_DATA;
          end else begin
            next_out_state = OUT_HOLD;
          end
        end else if (out_state == OUT_HOLD && selected) begin
          next_base      = edge_cnt;
          next_out_state = OUT_DATA;
        end else if (out_state == OUT_DATA && (at_end || deselect)) begin
          next_out_state = OUT_FLOAT;
        end
      end
      default: begin
        next_out_state = OUT_FLOAT;
      end
    endcase
  end

  // Result lands in the readout register at completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_state <= OUT_FLOAT;
      shreg     <= '0;
      base      <= '0;
      lead      <= 1'b0;
    end else begin
      out_state <= next_out_state;
      base      <= next_base;
      lead      <= next_lead;
      if (conv_done) begin
        shreg <= conv_result;
      end
    end
  end

  // Start bit is low in select mode, high in chain mode
  wire data_bit  = pick_bit(shreg, idx, lead, ~select_mode);
  wire idle_low  = out_state == OUT_FLOAT && both_low &&
                   conv_state == CONV_IDLE;
  asr_pin_s next_pin;

  // Pin value: bit stays put between falls, so both edges see it
  always_comb begin
    next_pin = '0;
    if (out_state == OUT_DATA && next_out_state == OUT_DATA) begin
      next_pin.data   = data_bit;
      next_pin.enable = 1'b1;
    end else if (idle_low) begin
      next_pin.data   = 1'b0;
      next_pin.enable = 1'b1;
    end
  end

  // All outputs from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_out    <= 1'b0;
      serial_data_out_en <= 1'b0;
      power_down         <= 1'b1;
      converting         <= 1'b0;
    end else begin
      serial_data_out    <= next_pin.data;
      serial_data_out_en <= next_pin.enable;
      power_down         <= next_conv_state == CONV_IDLE;
      converting         <= next_conv_state == CONV_RUN;
    end
  end

endmodule // asr_readout

// file: test/asr_readout_sva.sv
module asr_readout_sva
  import asr_pkg::*;
#(
  parameter int CONV_CYCLES = 35,
  parameter int EDGE_BITS   = 6
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        sck,
  input wire logic        convert_start,
  input wire logic        serial_data_in,
  input wire asr_sample_s analog_sample,
  input wire logic        serial_data_out,
  input wire logic        serial_data_out_en,
  input wire logic        power_down,
  input wire logic        converting
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sel_seen; // Data input level just before the start edge

  // Mode as the host set it; tied pins rise together and give chain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_seen <= 1'b0;
    end else if ($rose(convert_start) && !converting) begin
      sel_seen <= $past(serial_data_in);
    end
  end

  // One core domain; pins are sampled on the core clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_take_start: assert property (
    $rose(convert_start) && !converting |-> ##[1:5] converting)
    else $error("start edge not taken");
  chk_conv_length: assert property (
    $rose(converting) |-> converting[*8] ##1 converting[*8] ##1
      converting[*8] ##1 converting ##[1:11] !converting)
    else $error("conversion length out of range");
  chk_float_conv: assert property (
    converting |-> !serial_data_out_en)
    else $error("output driven during conversion");
  chk_awake_conv: assert property (
    converting |-> !power_down)
    else $error("powered down while converting");
  chk_sleep_done: assert property (
    $fell(converting) |-> ##[0:2] power_down)
    else $error("no power down after conversion");
  chk_busy_low: assert property (
    $fell(converting) && !convert_start |->
      ##[0:2] (serial_data_out_en && !serial_data_out))
    else $error("busy start bit missing");
  chk_plain_float: assert property (
    $fell(converting) && sel_seen && convert_start && serial_data_in |->
      !serial_data_out_en[*4])
    else $error("busy bit without cause");
  chk_deselect_float: assert property (
    $rose(convert_start) |-> ##[1:4] !serial_data_out_en)
    else $error("output not released on start edge");
  chk_idle_low: assert property (
    (!convert_start && !serial_data_in && !converting)[*8] |->
      serial_data_out_en && !serial_data_out)
    else $error("idle output not driven low");
endmodule // asr_readout_sva

bind asr_readout asr_readout_sva #(
  .CONV_CYCLES(CONV_CYCLES),
  .EDGE_BITS  (EDGE_BITS)
) u_asr_readout_sva (
  .clk               (clk),
  .reset_n           (reset_n),
  .sck               (sck),
  .convert_start     (convert_start),
  .serial_data_in    (serial_data_in),
  .analog_sample     (analog_sample),
  .serial_data_out   (serial_data_out),
  .serial_data_out_en(serial_data_out_en),
  .power_down        (power_down),
  .converting        (converting)
);

// file: test/asr_host.sv
module asr_host (
  output logic      sck,
  input  wire logic dout,
  input  wire logic dout_en,
  output wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic base; // 12 ns link time base, offset from core clock

  // Base never shares an edge with the core clock
  initial begin
    base = 1'h0;
    sck  = 1'h0;
    #3;
    forever #6 base = ~base;
  end

  // Pull-up on the host line when released; single device, no contention
  assign line = dout_en ? dout : 1'h1;

  // Serial clock level while idle, stands still outside frames
  task automatic set_level(input logic v);
    sck = v;
  endtask

  // One fall then a rise; slow halves keep each bit valid at both edges
  task automatic pulse;
    repeat (6) @(posedge base);
    sck = 1'h1;
    repeat (6) @(posedge base);
    sck = 1'h0;
    repeat (6) @(posedge base);
    sck = 1'h1;
  endtask
endmodule // asr_host

// file: test/asr_readout_bench.sv
module asr_readout_bench import asr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic        sel;  // Data input level at start edge
    logic        busy; // Start bit wanted
    asr_sample_s s;    // Front end value
    logic [16:0] exp;  // Expected frame
    logic [4:0]  n;    // Falls in the frame
  } asr_row_s;
  logic        clk, reset_n, convert_start, serial_data_in;
  logic        dout, dout_en, power_down, converting, sck, line;
  asr_sample_s analog_sample;
  int          fail_count, n_tests, conv_len;
  // Every mode and both saturation ends
  asr_row_s rows [6] = '{
    '{1'h1, 1'h0, '{16'hA5C3, 1'h0, 1'h0}, 17'h0A5C3, 5'h10},
    '{1'h1, 1'h1, '{16'h1234, 1'h0, 1'h0}, 17'h01234, 5'h11},
    '{1'h0, 1'h0, '{16'h8001, 1'h0, 1'h0}, 17'h08001, 5'h10},
    '{1'h0, 1'h1, '{16'h7FFE, 1'h0, 1'h0}, 17'h17FFE, 5'h11},
    '{1'h1, 1'h0, '{16'h1234, 1'h1, 1'h0}, 17'h0FFFF, 5'h10},
    '{1'h1, 1'h0, '{16'h00FF, 1'h0, 1'h1}, 17'h00000, 5'h10}};

  // 50 MHz core clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Short conversion keeps the run brief
  asr_readout #(.CONV_CYCLES(25)) u_asr_readout (.clk(clk),
    .reset_n(reset_n), .sck(sck), .convert_start(convert_start),
    .serial_data_in(serial_data_in), .analog_sample(analog_sample),
    .serial_data_out(dout), .serial_data_out_en(dout_en),
    .power_down(power_down), .converting(converting));
  asr_host u_asr_host (.sck(sck), .dout(dout), .dout_en(dout_en),
    .line(line));

  // Cycles spent converting
  always @(negedge clk) if (converting === 1'h1) conv_len++;

  task automatic check_word(input logic [16:0] got, input logic [16:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait, sampled away from the launching edge
  task automatic wait_conv(input logic lvl);
    for (int i = 0; i < 60 && converting !== lvl; i++) @(negedge clk);
    check_bit(converting, lvl);
  endtask
  // Mode level settles before the start edge
  task automatic start(input logic sel, input asr_sample_s s);
    @(posedge clk);
    serial_data_in <= sel;
    analog_sample  <= s;
    ticks(3);
    convert_start <= 1'h1;
    wait_conv(1'h1);
  endtask
  // First bit before any fall, then one bit per fall
  task automatic read(input int n, output logic [16:0] w);
    w = '0;
    #1 w = {w[15:0], line};
    for (int i = 1; i < n; i++) begin
      u_asr_host.pulse();
      #1 w = {w[15:0], line};
    end
    u_asr_host.pulse();
  endtask
  task automatic idle;
    @(posedge clk);
    convert_start  <= 1'h0;
    serial_data_in <= 1'h0;
    ticks(8);
    @(negedge clk);
    check_bit(dout_en, 1'h1);
    check_bit(line, 1'h0);
  endtask

  // Watchdog well past the expected run
  initial begin
    #200000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end

  initial begin
    asr_row_s    r;
    logic [16:0] w;
    reset_n = 1'h0;
    convert_start = 1'h0;
    serial_data_in = 1'h0;
    analog_sample = '0;
    ticks(10);
    @(negedge clk);
    check_bit(dout_en, 1'h0);
    check_bit(power_down, 1'h1);
    check_bit(converting, 1'h0);
    ticks(10);
    reset_n <= 1'h1;
    idle();
    // Table of ordinary frames
    for (int k = 0; k < 6; k++) begin
      r = rows[k];
      u_asr_host.set_level(r.sel | r.busy);
      start(r.sel, r.s);
      if (r.sel & r.busy) begin
        @(posedge clk);
        convert_start <= 1'h0;
      end
      wait_conv(1'h0);
      ticks(4);
      if (r.sel & !r.busy) begin
        convert_start <= 1'h0;
        ticks(5);
      end
      read(int'(r.n), w);
      check_word(w, r.exp);
      ticks(4);
      @(negedge clk);
      check_bit(dout_en, 1'h0);
      idle();
    end
    // Start edge during conversion is ignored
    u_asr_host.set_level(1'h1);
    conv_len = 0;
    start(1'h1, '{16'h4321, 1'h0, 1'h0});
    @(posedge clk);
    convert_start <= 1'h0;
    ticks(3);
    convert_start <= 1'h1;
    wait_conv(1'h0);
    check_word(17'(conv_len), 17'h00019);
    ticks(4);
    @(negedge clk);
    check_bit(dout_en, 1'h0);
    // Deselect in mid frame
    @(posedge clk);
    convert_start <= 1'h0;
    ticks(5);
    read(4, w);
    check_word(w, 17'h00004);
    @(posedge clk);
    convert_start <= 1'h1;
    ticks(4);
    @(negedge clk);
    check_bit(dout_en, 1'h0);
    wait_conv(1'h1);
    // Four wire: start stays high, data input selects the readout
    @(posedge clk);
    serial_data_in <= 1'h0;
    ticks(3);
    serial_data_in <= 1'h1;
    wait_conv(1'h0);
    ticks(4);
    serial_data_in <= 1'h0;
    ticks(5);
    read(16, w);
    check_word(w, 17'h04321);
    ticks(4);
    @(negedge clk);
    check_bit(dout_en, 1'h0);
    idle();
    // Tied pins rise together and pick chain mode
    u_asr_host.set_level(1'h0);
    @(posedge clk);
    analog_sample  <= '{16'hC001, 1'h0, 1'h0};
    convert_start  <= 1'h1;
    serial_data_in <= 1'h1;
    wait_conv(1'h1);
    wait_conv(1'h0);
    ticks(4);
    read(16, w);
    check_word(w, 17'h0C001);
    ticks(4);
    @(negedge clk);
    check_bit(dout_en, 1'h0);
    idle();
    // Reset in mid conversion drops back to acquisition
    start(1'h1, '{16'h0F0F, 1'h0, 1'h0});
    @(posedge clk);
    reset_n <= 1'h0;
    @(negedge clk);
    check_bit(converting, 1'h0);
    check_bit(power_down, 1'h1);
    check_bit(dout_en, 1'h0);
    ticks(3);
    reset_n <= 1'h1;
    idle();
    results();
  end
endmodule // asr_readout_bench
